// >>> otgl_edge_latch.sv
// OTG edge interrupt latch with APB register access
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "otgl_map.svh"

module otgl_edge_latch
    import otgl_pkg::*;
#(
    parameter int ADDR_W = 10
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              port2_dplus_request_detect,
    input  wire logic              port2_a_session_valid,
    input  wire logic              otg_timer_expired,
    input  wire logic              bdev_idle_se0_detect,
    input  wire logic              bdev_session_ended,
    input  wire logic              bdisconnect_aconnect,
    input  wire logic              remote_connect_seen,
    input  wire logic              id_pin_level,
    input  wire logic              port1_dplus_request_detect,
    input  wire logic              ab_session_valid,
    input  wire logic              bus_power_valid,
    output logic                   irq
);

    // Implemented bits and reset values as typed constants
    localparam otgl_word_type VALID      = `OTGL_VALID_MASK;
    localparam otgl_word_type RST_LATCH  = `OTGL_RESET_LATCH;
    localparam otgl_word_type RST_ENABLE = `OTGL_RESET_ENABLE;
    localparam otgl_word_type RST_MASK   = `OTGL_RESET_MASK;

    // Byte addresses reach index 0f6h times four
    initial
    begin
        if (ADDR_W < 10)
        begin
            $error("otgl_edge_latch: ADDR_W must be at least 10");
        end
    end

    // Every source position must be an implemented bit
    initial
    begin
        if (!VALID[`OTGL_BIT_P2_DPLUS]
            || !VALID[`OTGL_BIT_P2_ASESS]
            || !VALID[`OTGL_BIT_TIMER]
            || !VALID[`OTGL_BIT_SE0]
            || !VALID[`OTGL_BIT_SESS_END]
            || !VALID[`OTGL_BIT_BDISCONNECT_ACONNECT]
            || !VALID[`OTGL_BIT_REMOTE_CONNECT_SEEN]
            || !VALID[`OTGL_BIT_ID]
            || !VALID[`OTGL_BIT_P1_DPLUS]
            || !VALID[`OTGL_BIT_AB_SESS]
            || !VALID[`OTGL_BIT_VBUS])
        begin
            $error("otgl_edge_latch: source mapped onto a reserved bit");
        end
    end

    // Reset values must not set reserved bits
    initial
    begin
        if (((RST_LATCH | RST_ENABLE | RST_MASK) & ~VALID) != 16'h0000)
        begin
            $error("otgl_edge_latch: reset value touches a reserved bit");
        end
    end

    // Match of an address against the byte address of a register index
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
        hit = (addr == ADDR_W'({idx, 2'b00}));
    endfunction

    // Set and clear decode of a two-address register; set wins
    function automatic otgl_word_type set_clr(input otgl_word_type cur,
                                              input logic          do_set,
                                              input logic          do_clr,
                                              input otgl_word_type data);
        otgl_word_type res;
        res = cur;
        if (do_clr)
        begin
            res = res & ~data;
        end
        if (do_set)
        begin
            res = res | data;
        end
        set_clr = res;
    endfunction

    otgl_state_type q;
    otgl_state_type d;

    otgl_word_type  src_raw;
    otgl_word_type  rise_ev;
    otgl_word_type  fall_ev;
    otgl_word_type  hw_set;
    otgl_word_type  wdata;
    otgl_word_type  rd_word;
    logic           setup;
    logic           done;
    logic           wr;
    logic           mapped;
    logic [31:0]    rd_resp;

    // One select per register address
    logic           sel_source;
    logic           sel_latch_set;
    logic           sel_latch_clr;
    logic           sel_fall_set;
    logic           sel_fall_clr;
    logic           sel_rise_set;
    logic           sel_rise_clr;
    logic           sel_status;
    logic           sel_mask;

    // Write strobes of the access edge, and the status read flag taken in setup
    logic           we_latch_set;
    logic           we_latch_clr;
    logic           we_fall_set;
    logic           we_fall_clr;
    logic           we_rise_set;
    logic           we_rise_clr;
    logic           we_mask;
    logic           rd_status;

    // Gather the live sources at their bit positions
    always_comb
    begin
        src_raw                      = 16'h0000;
        src_raw[`OTGL_BIT_P2_DPLUS]  = port2_dplus_request_detect;
        src_raw[`OTGL_BIT_P2_ASESS]  = port2_a_session_valid;
        src_raw[`OTGL_BIT_TIMER]     = otg_timer_expired;
        src_raw[`OTGL_BIT_SE0]       = bdev_idle_se0_detect;
        src_raw[`OTGL_BIT_SESS_END]  = bdev_session_ended;
        src_raw[`OTGL_BIT_BDISCONNECT_ACONNECT] = bdisconnect_aconnect;
        src_raw[`OTGL_BIT_REMOTE_CONNECT_SEEN]  = remote_connect_seen;
        src_raw[`OTGL_BIT_ID]        = id_pin_level;
        src_raw[`OTGL_BIT_P1_DPLUS]  = port1_dplus_request_detect;
        src_raw[`OTGL_BIT_AB_SESS]   = ab_session_valid;
        src_raw[`OTGL_BIT_VBUS]      = bus_power_valid;
    end

    // Edge detection on synchronised sources, one slice per bit
    for (genvar gb = 0; gb < 16; gb++)
    begin : g_edge
        // Reserved positions never raise an event
        if (VALID[gb])
        begin : g_used
            assign rise_ev[gb] = q.sync2[gb] & ~q.prev[gb] & q.rise_en[gb];
            assign fall_ev[gb] = ~q.sync2[gb] & q.prev[gb] & q.fall_en[gb];
        end
        else
        begin : g_rsvd
            assign rise_ev[gb] = 1'b0;
            assign fall_ev[gb] = 1'b0;
        end
    end

    // Any enabled edge sets the latch
    assign hw_set = rise_ev | fall_ev;

    // Bus phase and byte-lane write data
    always_comb
    begin
        setup  = psel & ~penable;
        done   = psel & penable & q.pready;
        wr     = done & pwrite;
        wdata  = pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}} & `OTGL_VALID_MASK;
        mapped = hit(paddr, `OTGL_IDX_SOURCE)
               | hit(paddr, `OTGL_IDX_LATCH_SET)
               | hit(paddr, `OTGL_IDX_LATCH_CLR)
               | hit(paddr, `OTGL_IDX_FALL_SET)
               | hit(paddr, `OTGL_IDX_FALL_CLR)
               | hit(paddr, `OTGL_IDX_RISE_SET)
               | hit(paddr, `OTGL_IDX_RISE_CLR)
               | hit(paddr, `OTGL_IDX_IRQ_STATUS)
               | hit(paddr, `OTGL_IDX_IRQ_MASK);
    end

    // Address decode, one select per register
    always_comb
    begin
        sel_source    = hit(paddr, `OTGL_IDX_SOURCE);
        sel_latch_set = hit(paddr, `OTGL_IDX_LATCH_SET);
        sel_latch_clr = hit(paddr, `OTGL_IDX_LATCH_CLR);
        sel_fall_set  = hit(paddr, `OTGL_IDX_FALL_SET);
        sel_fall_clr  = hit(paddr, `OTGL_IDX_FALL_CLR);
        sel_rise_set  = hit(paddr, `OTGL_IDX_RISE_SET);
        sel_rise_clr  = hit(paddr, `OTGL_IDX_RISE_CLR);
        sel_status    = hit(paddr, `OTGL_IDX_IRQ_STATUS);
        sel_mask      = hit(paddr, `OTGL_IDX_IRQ_MASK);
    end

    // Write strobes; a write lands only at the access edge
    always_comb
    begin
        we_latch_set = wr & sel_latch_set;
        we_latch_clr = wr & sel_latch_clr;
        we_fall_set  = wr & sel_fall_set;
        we_fall_clr  = wr & sel_fall_clr;
        we_rise_set  = wr & sel_rise_set;
        we_rise_clr  = wr & sel_rise_clr;
        we_mask      = wr & sel_mask;
        rd_status    = ~pwrite & sel_status & ~sel_source;
    end

    // Answer word: reads carry the register, writes carry zero
    always_comb
    begin
        rd_resp = 32'h0000_0000;
        if (!pwrite)
        begin
            rd_resp = {16'h0000, rd_word};
        end
    end

    // Read multiplexer; reserved bits stay zero
    always_comb
    begin
        rd_word = 16'h0000;
        if (hit(paddr, `OTGL_IDX_SOURCE))
        begin
            rd_word = q.sync2;
        end
        else if (hit(paddr, `OTGL_IDX_LATCH_SET) || hit(paddr, `OTGL_IDX_LATCH_CLR))
        begin
            rd_word = q.latch;
        end
        else if (hit(paddr, `OTGL_IDX_FALL_SET) || hit(paddr, `OTGL_IDX_FALL_CLR))
        begin
            rd_word = q.fall_en;
        end
        else if (hit(paddr, `OTGL_IDX_RISE_SET) || hit(paddr, `OTGL_IDX_RISE_CLR))
        begin
            rd_word = q.rise_en;
        end
        else if (hit(paddr, `OTGL_IDX_IRQ_STATUS))
        begin
            rd_word = q.stat;
        end
        else if (hit(paddr, `OTGL_IDX_IRQ_MASK))
        begin
            rd_word = q.mask;
        end
        rd_word = rd_word & `OTGL_VALID_MASK;
    end

    // Next state
    always_comb
    begin
        d = q;

        // Two-stage synchroniser, then edge history
        d.sync1 = src_raw;
        d.sync2 = q.sync1;
        d.prev  = q.sync2;

        // Latch: hardware set wins over software clear, held otherwise
        d.latch = set_clr(q.latch,
                          we_latch_set,
                          we_latch_clr,
                          wdata);
        d.latch = d.latch | hw_set;

        // Edge enables
        d.fall_en = set_clr(q.fall_en,
                            we_fall_set,
                            we_fall_clr,
                            wdata);
        d.rise_en = set_clr(q.rise_en,
                            we_rise_set,
                            we_rise_clr,
                            wdata);

        // Interrupt mask
        if (we_mask)
        begin
            d.mask = wdata;
        end

        // Status clears only what the read returned; new events win
        if (done && q.stat_rd)
        begin
            d.stat = q.stat & ~q.prdata[15:0];
        end
        d.stat = d.stat | hw_set;

        // Bus answer prepared in setup, presented during access
        d.pready  = 1'b0;
        d.stat_rd = 1'b0;
        if (setup)
        begin
            d.pready  = 1'b1;
            d.pslverr = ~mapped;
            d.prdata  = rd_resp;
            d.stat_rd = rd_status;
        end
        else if (done)
        begin
            d.pslverr = 1'b0;
            d.prdata  = 32'h0000_0000;
        end

        d.irq = |(d.stat & d.mask);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q         <= '0;
            q.latch   <= `OTGL_RESET_LATCH;
            q.fall_en <= `OTGL_RESET_ENABLE;
            q.rise_en <= `OTGL_RESET_ENABLE;
            q.mask    <= `OTGL_RESET_MASK;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign pready  = q.pready;
    assign prdata  = q.prdata;
    assign pslverr = q.pslverr;
    assign irq     = q.irq;

endmodule

// >>> otgl_edge_latch_assertions.sv
// Port assertions for the OTG edge latch
`timescale 1ns/1ns
module otgl_edge_latch_chk #(parameter int ADDR_W = 10)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              irq
);
    // One clock domain, reset disables all
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    chk_setup_answer: assert property (psel && !penable |=> pready)
        else $error("no answer to setup");
    chk_ready_cause: assert property (!(psel && !penable) |=> !pready)
        else $error("pready without setup");
    chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper data not zero");
    chk_rsvd_zero: assert property (pready && !pslverr |-> prdata[15:12] == 4'h0 && !prdata[5])
        else $error("reserved bits not zero");
    chk_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    chk_unmapped_err: assert property (psel && !penable && paddr == '0 |=> pslverr)
        else $error("unmapped not refused");
    chk_irq_sticky: assert property ($fell(irq) |-> $past(psel && penable))
        else $error("irq dropped by itself");
endmodule

bind otgl_edge_latch otgl_edge_latch_chk #(.ADDR_W(ADDR_W)) chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq(irq));

// >>> otgl_host_model.sv
// Bus master model standing in for the host processor
`timescale 1ns/1ns
module otgl_host_model
(
    input wire logic   pclk,
    output logic       psel,
    output logic       penable,
    output logic       pwrite,
    output logic [9:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic   pready,
    input wire logic [31:0] prdata,
    input wire logic   pslverr
);
    // Idle bus from time zero
    initial
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;

    // One transfer: setup, access held until pready
    task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= i * 10'd4;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (!pready);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
endmodule

// >>> otgl_map.svh
// Register indices, bit positions, reset values and masks of the OTG edge latch
`ifndef OTGL_MAP_SVH
`define OTGL_MAP_SVH

// Register indices; byte address is four times the index
`define OTGL_IDX_SOURCE     10'h0e8
`define OTGL_IDX_LATCH_SET  10'h0ec
`define OTGL_IDX_LATCH_CLR  10'h0ee
`define OTGL_IDX_FALL_SET   10'h0f0
`define OTGL_IDX_FALL_CLR   10'h0f2
`define OTGL_IDX_RISE_SET   10'h0f4
`define OTGL_IDX_RISE_CLR   10'h0f6
`define OTGL_IDX_IRQ_STATUS 10'h0d0
`define OTGL_IDX_IRQ_MASK   10'h0d2

// Source bit positions
`define OTGL_BIT_P2_DPLUS   11
`define OTGL_BIT_P2_ASESS   10
`define OTGL_BIT_TIMER      9
`define OTGL_BIT_SE0        8
`define OTGL_BIT_SESS_END   7
`define OTGL_BIT_BDISCONNECT_ACONNECT  6
`define OTGL_BIT_REMOTE_CONNECT_SEEN   4
`define OTGL_BIT_ID         3
`define OTGL_BIT_P1_DPLUS   2
`define OTGL_BIT_AB_SESS    1
`define OTGL_BIT_VBUS       0

// Implemented bits; bit 5 and bits 15 to 12 are reserved
`define OTGL_VALID_MASK     16'h0fdf
`define OTGL_RESET_LATCH    16'h0000
`define OTGL_RESET_ENABLE   16'h0000
`define OTGL_RESET_MASK     16'h0000

`endif

// >>> otgl_pkg.sv
// Types shared by the OTG edge latch
package otgl_pkg;

    typedef logic [15:0] otgl_word_type;

    // Complete state of the block
    typedef struct packed {
        otgl_word_type sync1;
        otgl_word_type sync2;
        otgl_word_type prev;
        otgl_word_type latch;
        otgl_word_type fall_en;
        otgl_word_type rise_en;
        otgl_word_type stat;
        otgl_word_type mask;
        logic          stat_rd;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        logic          irq;
    } otgl_state_type;

endpackage

// >>> tb_otg_edge_interrupt_latch.sv
// Self-checking bench for the OTG edge latch
`timescale 1ns/1ns
`include "otgl_map.svh"
module tb_otg_edge_interrupt_latch;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [15:0] src_v;
    int          cyc, n_fail, cmp_count;
    logic [9:0]  ids [9] = '{`OTGL_IDX_SOURCE, `OTGL_IDX_LATCH_SET, `OTGL_IDX_LATCH_CLR, `OTGL_IDX_FALL_SET,
        `OTGL_IDX_FALL_CLR, `OTGL_IDX_RISE_SET, `OTGL_IDX_RISE_CLR, `OTGL_IDX_IRQ_STATUS, `OTGL_IDX_IRQ_MASK};

    otgl_edge_latch otgl_edge_latch_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .port2_dplus_request_detect(src_v[11]),
        .port2_a_session_valid(src_v[10]), .otg_timer_expired(src_v[9]), .bdev_idle_se0_detect(src_v[8]),
        .bdev_session_ended(src_v[7]), .bdisconnect_aconnect(src_v[6]), .remote_connect_seen(src_v[4]),
        .id_pin_level(src_v[3]), .port1_dplus_request_detect(src_v[2]), .ab_session_valid(src_v[1]),
        .bus_power_valid(src_v[0]));
    otgl_host_model otgl_host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    // Clock and hang guard
    always #20 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            results();
        end
    end

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        otgl_host_model_i.xfer(1'b1, i, d, rdat, err);
    endtask
    task automatic rd(input logic [9:0] i, input string n, input logic [31:0] exp);
        otgl_host_model_i.xfer(1'b0, i, 32'h0, rdat, err);
        chk(n, rdat, exp);
    endtask
    // Sources change, then settle past the sync stages
    task automatic drive(input logic [15:0] v);
        @(posedge pclk);
        src_v <= v;
        repeat (5) @(posedge pclk);
    endtask

    task automatic t_reset;
        foreach (ids[k])
            rd(ids[k], "reset value", 32'h0);
        rd(10'h000, "unmapped data", 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_rise;
        wr(`OTGL_IDX_RISE_SET, 32'h0000ffff);
        drive(16'h0fdf);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rd(`OTGL_IDX_LATCH_CLR, "latch rise", 32'h0fdf);
        rd(`OTGL_IDX_SOURCE, "source", 32'h0fdf);
        chk("mapped err", {31'h0, err}, 32'h0);
        wr(`OTGL_IDX_IRQ_MASK, 32'h0000ffff);
        @(posedge pclk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        drive(16'h0000);
        rd(`OTGL_IDX_LATCH_SET, "latch sticky", 32'h0fdf);
        rd(`OTGL_IDX_IRQ_STATUS, "status", 32'h0fdf);
        rd(`OTGL_IDX_IRQ_STATUS, "status cleared", 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(`OTGL_IDX_LATCH_CLR, 32'h000000ff);
        wr(`OTGL_IDX_LATCH_SET, 32'h00000020);
        rd(`OTGL_IDX_LATCH_SET, "latch clear", 32'h0f00);
        wr(`OTGL_IDX_RISE_CLR, 32'h0000ffff);
        wr(`OTGL_IDX_IRQ_MASK, 32'h0);
        wr(`OTGL_IDX_LATCH_CLR, 32'h0000ffff);
        $display("test rise done");
    endtask

    // One fall enable at a time: only its own bit may latch
    task automatic t_fall;
        for (int b = 0; b < 12; b++)
        begin
            wr(`OTGL_IDX_FALL_SET, 32'h1 << b);
            drive(16'h0fff);
            rd(`OTGL_IDX_LATCH_SET, "no rise latch", 32'h0);
            drive(16'h0000);
            rd(`OTGL_IDX_FALL_CLR, "fall enable", 32'(`OTGL_VALID_MASK & (16'h1 << b)));
            rd(`OTGL_IDX_LATCH_SET, "latch fall", 32'(`OTGL_VALID_MASK & (16'h1 << b)));
            wr(`OTGL_IDX_FALL_CLR, 32'h1 << b);
            wr(`OTGL_IDX_LATCH_CLR, 32'h0000ffff);
        end
        rd(`OTGL_IDX_FALL_SET, "fall cleared", 32'h0);
        $display("test fall done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Reset for four cycles, then the tests
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        src_v = 16'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rise();
        t_fall();
        results();
    end
endmodule
